/* shared/npc_pkg.sv */
// Constants, types and field layouts for the network phase controller.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
package npc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int BAUD0_HZ = 12000000;
  localparam int BAUD1_HZ = 6000000;
  localparam int BAUD2_HZ = 3000000;
  localparam int BAUD3_HZ = 1500000;
  localparam logic [7:0] BIT_CYC_0 = 8'(CLK_HZ / BAUD0_HZ);
  localparam logic [7:0] BIT_CYC_1 = 8'(CLK_HZ / BAUD1_HZ);
  localparam logic [7:0] BIT_CYC_2 = 8'(CLK_HZ / BAUD2_HZ);
  localparam logic [7:0] BIT_CYC_3 = 8'(CLK_HZ / BAUD3_HZ);

  // ----------------------------------------
  // Frame and cycle figures
  // ----------------------------------------
  localparam logic [8:0] LOF_STD = 9'h097;
  localparam logic [8:0] LOF_LONG = 9'h100;
  localparam logic [6:0] PUBLIC_FRAME_COUNT = 7'h02;
  localparam logic [5:0] FS_RESET = 6'h3F;
  localparam logic [1:0] START_CYCLES = 2'h2;
  localparam logic [5:0] STOP_CYCLES = 6'h20;

  // ----------------------------------------
  // System control word fields
  // ----------------------------------------
  localparam int SCW_ST_LSB = 0;
  localparam int SCW_ST_W = 7;
  localparam int SCW_START = 8;
  localparam int SCW_RUN = 9;
  localparam int SCW_CALL = 10;
  localparam int SCW_BRK = 11;
  localparam int SCW_SLOT = 12;
  localparam int SCW_ISO = 13;
  localparam int SCW_MM = 15;

  // ----------------------------------------
  // Basic configuration register fields
  // ----------------------------------------
  localparam int BCR_SA_LSB = 0;
  localparam int BCR_BPS_LSB = 6;
  localparam int BCR_OWN_LSB = 8;
  localparam int BCR_LFS = 15;
  localparam logic [15:0] BCR_RESET = 16'h0000;
  localparam logic [6:0] ALARM_RESET = 7'h00;
  localparam logic [6:0] GM_BLOCKS = 7'h40;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_START, PH_CALL, PH_RUN, PH_BREAK} npc_phase_t;

  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } npc_hwr_t;

  typedef struct packed {
    logic wr;
    logic [8:0] addr;
  } npc_gmwr_t;

  typedef struct packed {
    logic link_ok;
    logic rx_ok;
    logic peer_seen;
    logic slot_ok;
  } npc_link_t;

  typedef struct packed {
    logic valid;
    logic [5:0] fs;
  } npc_resize_t;

endpackage

/* rtl/npc_timer.sv */
// Frame and cycle timer: bit periods, frame length and station time.
// Assumes its caller holds i_run high only while the network is started.
`timescale 1ns/10ps
module npc_timer
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [7:0] i_bit_cyc,
  input wire logic [8:0] i_lof,
  input wire logic [5:0] i_fs,
  output logic [6:0] o_st,
  output logic o_frame_tick,
  output logic o_cycle_tick
);

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic [7:0] bit_cnt_r;
  logic [10:0] half_cnt_r;
  logic [6:0] st_r;
  logic frame_tick_r;
  logic cycle_tick_r;

  wire logic [9:0] frame_bits = 10'(i_lof) + 10'(i_fs) + 10'h001;
  wire logic [10:0] frame_halves = {frame_bits, 1'b0};
  wire logic [6:0] last_st = 7'(i_fs) + npc_pkg::PUBLIC_FRAME_COUNT;
  wire logic bit_tick = i_run && (bit_cnt_r == i_bit_cyc - 8'h01);
  wire logic frame_end = bit_tick && (half_cnt_r >= frame_halves - 11'h001);
  wire logic cycle_end = frame_end && (st_r >= last_st);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run || bit_tick)
      bit_cnt_r <= 8'h00;
    else
      bit_cnt_r <= bit_cnt_r + 8'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run || frame_end)
      half_cnt_r <= 11'h000;
    else if (bit_tick)
      half_cnt_r <= half_cnt_r + 11'h001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run || cycle_end)
      st_r <= 7'h00;
    else if (frame_end)
      st_r <= st_r + 7'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      frame_tick_r <= 1'b0;
      cycle_tick_r <= 1'b0;
    end
    else
    begin
      frame_tick_r <= frame_end;
      cycle_tick_r <= cycle_end;
    end
  end

  assign o_st = st_r;
  assign o_frame_tick = frame_tick_r;
  assign o_cycle_tick = cycle_tick_r;

endmodule

/* rtl/npc_core.sv */
// Network phase controller: phases, write protection, timing and stops.
// Assumes link logic reports per-cycle activity and resize events on ports.
//
// Overview of operation
// - After start, leave START for waiting, running or break-out within two or three cycles.
// - Running flag at bit 9 while the network runs normally.
// - Waiting flag at bit 10 while no other started station is present.
// - Break-out flag at bit 11 until other stations resize to admit us.
// - Memory-monitor bit accepts a one only while the start flag is zero.
// - While started, block global memory writes outside the owned area.
// - Configuration register writable only when stopped and memory-monitor is one.
// - Mail transfers only while the running flag is one.
// - Frame time (length + final station + 1) x 2 bits; cycle adds frames.
// - Frame length 151, public frame count 2, long-frame option gives 256.
// - Final station register starts at 63 and changes only by resize.
// - Station time shown in bits 0 to 6 of the control word.
// - Alarm trigger when station time equals a host-preset value.
// - Host writing zero to start stops the network and clears phase flags.
// - Running phase stops after 32 consecutive cycles with no link.
// - Break-out phase stops with isolation after 32 cycles with nothing received.
// - Resize leaving part of the owned area without a slot stops with slot loss.
// - Isolation and slot-loss stops only in running or break-out phase.
// - Isolation stop clears running and start, sets isolation flag bit 13.
// - Slot-loss stop clears running and start, sets slot-loss flag bit 12.
// - Interrupt trigger output whenever the network stops.
// - Start write of one or reset clears isolation and slot-loss flags.
// - Start flag is bit 8 of the control word.
// - Memory-monitor bit is bit 15 of the control word.
`timescale 1ns/10ps
module npc_core
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire npc_pkg::npc_hwr_t i_scw_wr,
  input wire npc_pkg::npc_hwr_t i_bcr_wr,
  input wire logic i_alarm_wr,
  input wire logic [6:0] i_alarm_val,
  input wire npc_pkg::npc_gmwr_t i_gm_wr,
  input wire logic i_mail_req,
  input wire npc_pkg::npc_link_t i_link,
  input wire npc_pkg::npc_resize_t i_resize,
  output logic [15:0] o_scw,
  output logic [15:0] o_bcr,
  output logic [5:0] o_fsr,
  output logic [6:0] o_alarm_val,
  output logic o_gm_wr_ok,
  output logic o_mail_ok,
  output logic o_frame_tick,
  output logic o_cycle_tick,
  output logic o_alarm,
  output logic o_stop_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  npc_pkg::npc_phase_t phase_r;
  npc_pkg::npc_phase_t phase_nxt;
  logic start_r;
  logic start_nxt;
  logic mm_r;
  logic mm_nxt;
  logic iso_r;
  logic slot_r;
  logic [15:0] bcr_r;
  logic [5:0] fsr_r;
  logic [6:0] alarm_r;
  logic [1:0] start_cnt_r;
  logic [5:0] miss_cnt_r;
  logic seen_r;
  logic alarm_hit_r;
  logic stop_irq_r;
  logic [6:0] st;
  logic frame_tick;
  logic cycle_tick;

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  wire logic ph_run = (phase_r == npc_pkg::PH_RUN);
  wire logic ph_call = (phase_r == npc_pkg::PH_CALL);
  wire logic ph_brk = (phase_r == npc_pkg::PH_BREAK);
  wire logic ph_live = ph_run || ph_brk;

  // ----------------------------------------
  // Host write decode
  // ----------------------------------------
  wire logic host_zero = i_scw_wr.wr && !i_scw_wr.data[npc_pkg::SCW_START];
  wire logic host_one = i_scw_wr.wr && i_scw_wr.data[npc_pkg::SCW_START];
  wire logic host_start = host_one && !start_r;
  wire logic mm_set_ok = !start_r;
  wire logic bcr_ok = i_bcr_wr.wr && !start_r && mm_r;

  // ----------------------------------------
  // Owned area
  // ----------------------------------------
  wire logic [5:0] sa = bcr_r[npc_pkg::BCR_SA_LSB +: 6];
  wire logic [5:0] own = bcr_r[npc_pkg::BCR_OWN_LSB +: 6];
  wire logic [6:0] own_w = (own == 6'h00) ? 7'h01 : 7'(own);
  wire logic [6:0] own_end = 7'(sa) + own_w;
  wire logic [5:0] own_last = (own_end > npc_pkg::GM_BLOCKS) ? 6'h3F : 6'(own_end - 7'h01);
  wire logic [5:0] gm_block = i_gm_wr.addr[8:3];
  wire logic in_own = (gm_block >= sa) && (gm_block <= own_last);

  // ----------------------------------------
  // Timing selection
  // ----------------------------------------
  wire logic [1:0] bps = bcr_r[npc_pkg::BCR_BPS_LSB +: 2];
  wire logic [7:0] bit_cyc = (bps == 2'h0) ? npc_pkg::BIT_CYC_0 :
                             (bps == 2'h1) ? npc_pkg::BIT_CYC_1 :
                             (bps == 2'h2) ? npc_pkg::BIT_CYC_2 : npc_pkg::BIT_CYC_3;
  wire logic [8:0] frame_length = bcr_r[npc_pkg::BCR_LFS] ? npc_pkg::LOF_LONG : npc_pkg::LOF_STD;

  // ----------------------------------------
  // Stop causes
  // ----------------------------------------
  wire logic activity = ph_run ? i_link.link_ok : i_link.rx_ok;
  wire logic quiet_cycle = cycle_tick && !seen_r && !activity;
  wire logic iso_evt = ph_live && quiet_cycle && (miss_cnt_r == npc_pkg::STOP_CYCLES - 6'h01);
  wire logic slot_evt = ph_live && i_resize.valid && (i_resize.fs < own_last);
  wire logic auto_stop = iso_evt || slot_evt;
  wire logic net_stop = start_r && (host_zero || auto_stop);

  // ----------------------------------------
  // Start and memory-monitor bits
  // ----------------------------------------
  always_comb
  begin
    start_nxt = start_r;
    if (auto_stop)
      start_nxt = 1'b0;
    else if (host_zero)
      start_nxt = 1'b0;
    else if (host_one)
      start_nxt = 1'b1;
  end

  always_comb
  begin
    mm_nxt = mm_r;
    if (i_scw_wr.wr)
    begin
      if (!i_scw_wr.data[npc_pkg::SCW_MM])
        mm_nxt = 1'b0;
      else if (mm_set_ok)
        mm_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  always_comb
  begin
    phase_nxt = phase_r;
    case (phase_r)
      npc_pkg::PH_IDLE:
      begin
        if (host_start)
          phase_nxt = npc_pkg::PH_START;
      end
      npc_pkg::PH_START:
      begin
        if (cycle_tick && (start_cnt_r == npc_pkg::START_CYCLES - 2'h1))
        begin
          if (!i_link.peer_seen)
            phase_nxt = npc_pkg::PH_CALL;
          else if (i_link.slot_ok)
            phase_nxt = npc_pkg::PH_RUN;
          else
            phase_nxt = npc_pkg::PH_BREAK;
        end
      end
      npc_pkg::PH_CALL:
      begin
        if (cycle_tick && i_link.peer_seen)
          phase_nxt = i_link.slot_ok ? npc_pkg::PH_RUN : npc_pkg::PH_BREAK;
      end
      npc_pkg::PH_BREAK:
      begin
        if (cycle_tick && i_link.slot_ok)
          phase_nxt = npc_pkg::PH_RUN;
      end
      npc_pkg::PH_RUN:
      begin
        phase_nxt = npc_pkg::PH_RUN;
      end
      default:
      begin
        phase_nxt = npc_pkg::PH_IDLE;
      end
    endcase
    if (!start_nxt)
      phase_nxt = npc_pkg::PH_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      phase_r <= npc_pkg::PH_IDLE;
    else
      phase_r <= phase_nxt;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || phase_r != npc_pkg::PH_START)
      start_cnt_r <= 2'h0;
    else if (cycle_tick)
      start_cnt_r <= start_cnt_r + 2'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      start_r <= 1'b0;
      mm_r <= 1'b0;
    end
    else
    begin
      start_r <= start_nxt;
      mm_r <= mm_nxt;
    end
  end

  // ----------------------------------------
  // Stop flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      iso_r <= 1'b0;
      slot_r <= 1'b0;
    end
    else
    begin
      iso_r <= iso_evt || (iso_r && !host_one);
      slot_r <= slot_evt || (slot_r && !host_one);
    end
  end

  // ----------------------------------------
  // Isolation watch
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst || cycle_tick || !ph_live)
      seen_r <= 1'b0;
    else if (activity)
      seen_r <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !ph_live || phase_nxt != phase_r)
      miss_cnt_r <= 6'h00;
    else if (quiet_cycle)
      miss_cnt_r <= miss_cnt_r + 6'h01;
    else if (cycle_tick)
      miss_cnt_r <= 6'h00;
  end

  // ----------------------------------------
  // Configuration, final station, alarm preset
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      bcr_r <= npc_pkg::BCR_RESET;
    else if (bcr_ok)
      bcr_r <= i_bcr_wr.data;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      fsr_r <= npc_pkg::FS_RESET;
    else if (i_resize.valid && start_r)
      fsr_r <= i_resize.fs;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      alarm_r <= npc_pkg::ALARM_RESET;
    else if (i_alarm_wr)
      alarm_r <= i_alarm_val;
  end

  // ----------------------------------------
  // Trigger pulses
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      alarm_hit_r <= 1'b0;
      stop_irq_r <= 1'b0;
    end
    else
    begin
      alarm_hit_r <= start_r && frame_tick && (st == alarm_r);
      stop_irq_r <= net_stop;
    end
  end

  // ----------------------------------------
  // Frame timer
  // ----------------------------------------
  npc_timer u_timer
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(start_r),
    .i_bit_cyc(bit_cyc),
    .i_lof(frame_length),
    .i_fs(fsr_r),
    .o_st(st),
    .o_frame_tick(frame_tick),
    .o_cycle_tick(cycle_tick)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb
  begin
    o_scw = 16'h0000;
    o_scw[npc_pkg::SCW_ST_LSB +: npc_pkg::SCW_ST_W] = st;
    o_scw[npc_pkg::SCW_START] = start_r;
    o_scw[npc_pkg::SCW_RUN] = ph_run;
    o_scw[npc_pkg::SCW_CALL] = ph_call;
    o_scw[npc_pkg::SCW_BRK] = ph_brk;
    o_scw[npc_pkg::SCW_SLOT] = slot_r;
    o_scw[npc_pkg::SCW_ISO] = iso_r;
    o_scw[npc_pkg::SCW_MM] = mm_r;
  end

  assign o_bcr = bcr_r;
  assign o_fsr = fsr_r;
  assign o_alarm_val = alarm_r;
  assign o_gm_wr_ok = i_gm_wr.wr && (!start_r || in_own);
  assign o_mail_ok = i_mail_req && ph_run;
  assign o_frame_tick = frame_tick;
  assign o_cycle_tick = cycle_tick;
  assign o_alarm = alarm_hit_r;
  assign o_stop_irq = stop_irq_r;

endmodule

/* test/npc_core_assertions.sv */
// Checker for the network phase controller, on the top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module npc_core_assertions
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire npc_pkg::npc_hwr_t i_scw_wr,
  input wire npc_pkg::npc_hwr_t i_bcr_wr,
  input wire npc_pkg::npc_gmwr_t i_gm_wr,
  input wire logic i_mail_req,
  input wire npc_pkg::npc_resize_t i_resize,
  input wire logic [15:0] o_scw,
  input wire logic [15:0] o_bcr,
  input wire logic [6:0] o_alarm_val,
  input wire logic o_gm_wr_ok,
  input wire logic o_mail_ok,
  input wire logic o_frame_tick,
  input wire logic o_cycle_tick,
  input wire logic o_alarm,
  input wire logic o_stop_irq
);
  // ----------------------------------------
  // Owned range and start tick count
  // ----------------------------------------
  wire logic [5:0] own_w = (o_bcr[13:8] == 6'h00) ? 6'h01 : o_bcr[13:8];
  wire logic [6:0] sum_w = {1'b0, o_bcr[5:0]} + {1'b0, own_w} - 7'h01;
  wire logic [5:0] last_w = (sum_w > 7'h3F) ? 6'h3F : sum_w[5:0];
  wire logic in_start_w = o_scw[8] && (o_scw[11:9] == 3'h0);
  wire logic in_own_w = (i_gm_wr.addr[8:3] >= o_bcr[5:0]) && (i_gm_wr.addr[8:3] <= last_w);
  logic [2:0] tick_cnt_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !in_start_w) tick_cnt_r <= 3'h0;
    else if (o_cycle_tick && (tick_cnt_r != 3'h7)) tick_cnt_r <= tick_cnt_r + 3'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_resize_cut;
    i_resize.valid && (o_scw[9] || o_scw[11]) && (i_resize.fs < last_w);
  endsequence
  sequence s_slot_stop;
    o_scw[12] && !o_scw[8] && !o_scw[9];
  endsequence
  AST_LEAVE_START: assert property (tick_cnt_r <= 3'h3)
    else $error("start phase held too long");
  AST_MM_LOCK: assert property (i_scw_wr.wr && o_scw[8] && !o_scw[15] |=> !o_scw[15])
    else $error("monitor bit set while started");
  AST_GM_GATE: assert property (o_gm_wr_ok == (i_gm_wr.wr && (!o_scw[8] || in_own_w)))
    else $error("memory write gate wrong");
  AST_BCR_LOCK: assert property (i_bcr_wr.wr && (o_scw[8] || !o_scw[15]) |=> $stable(o_bcr))
    else $error("config changed while locked");
  AST_BCR_TAKE: assert property (i_bcr_wr.wr && !o_scw[8] && o_scw[15] |=> o_bcr == $past(i_bcr_wr.data))
    else $error("config write lost");
  AST_MAIL: assert property (o_mail_ok == (i_mail_req && o_scw[9]))
    else $error("mail gate wrong");
  AST_EXCL: assert property ($onehot0(o_scw[11:9]) && (o_scw[8] || (o_scw[11:9] == 3'h0)))
    else $error("phase flags not exclusive");
  AST_HOST_STOP: assert property (i_scw_wr.wr && !i_scw_wr.data[8] |=> o_scw[11:8] == 4'h0)
    else $error("host stop left flags");
  AST_SLOT_STOP: assert property (s_resize_cut |-> ##[1:2] s_slot_stop)
    else $error("slot loss stop missing");
  AST_ISO_STOP: assert property ($rose(o_scw[13]) |-> !o_scw[8] && !o_scw[9])
    else $error("isolation stop left run");
  AST_STOP_IRQ: assert property ($fell(o_scw[8]) && !$past(i_rst) |-> ##[0:1] o_stop_irq)
    else $error("stop trigger missing");
  AST_FLAG_CLR: assert property (i_scw_wr.wr && i_scw_wr.data[8] && !o_scw[8] |=> o_scw[13:12] == 2'h0)
    else $error("stop flags not cleared");
  AST_ALARM: assert property (o_alarm |-> $past(o_frame_tick) && ($past(o_scw[6:0]) == $past(o_alarm_val)))
    else $error("alarm without match");
endmodule

bind npc_core npc_core_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_scw_wr(i_scw_wr),
  .i_bcr_wr(i_bcr_wr), .i_gm_wr(i_gm_wr), .i_mail_req(i_mail_req), .i_resize(i_resize), .o_scw(o_scw),
  .o_bcr(o_bcr), .o_alarm_val(o_alarm_val), .o_gm_wr_ok(o_gm_wr_ok), .o_mail_ok(o_mail_ok),
  .o_frame_tick(o_frame_tick), .o_cycle_tick(o_cycle_tick), .o_alarm(o_alarm), .o_stop_irq(o_stop_irq));

/* test/npc_peer_model.sv */
// Model of the other stations as seen through the link logic.
// Assumes the bench sets peer presence and admission.
`timescale 1ns/10ps
module npc_peer_model
(
  input wire logic i_clk,
  input wire logic i_peer,
  input wire logic i_admit,
  output npc_pkg::npc_link_t o_link
);
  // ----------------------------------------
  // Link levels
  // ----------------------------------------
  initial o_link = '0;
  always @(negedge i_clk)
  begin
    o_link.link_ok <= i_peer;
    o_link.rx_ok <= i_peer;
    o_link.peer_seen <= i_peer;
    o_link.slot_ok <= i_peer && i_admit;
  end
endmodule

/* test/testbench.sv */
// Self-checking bench for the network phase controller.
// Assumes the peer model and the bound checker.
`timescale 1ns/10ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  npc_pkg::npc_hwr_t scw_wr = '0;
  npc_pkg::npc_hwr_t bcr_wr = '0;
  npc_pkg::npc_gmwr_t gm_wr = '0;
  npc_pkg::npc_resize_t resize = '0;
  npc_pkg::npc_link_t link;
  logic alarm_wr = 1'b0;
  logic [6:0] alarm_in = 7'h00;
  logic mail_req = 1'b0;
  logic peer = 1'b0;
  logic admit = 1'b0;
  logic [15:0] scw;
  logic [15:0] basic_configuration_register;
  logic [5:0] final_station_register;
  logic [6:0] alarm_val;
  logic gm_ok;
  logic mail_ok;
  logic frame_tick;
  logic cycle_tick;
  logic alarm;
  logic stop_irq;
  logic irq_seen = 1'b0;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;

  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  always #4 i_clk = ~i_clk;
  npc_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_scw_wr(scw_wr), .i_bcr_wr(bcr_wr), .i_alarm_wr(alarm_wr),
    .i_alarm_val(alarm_in), .i_gm_wr(gm_wr), .i_mail_req(mail_req), .i_link(link), .i_resize(resize),
    .o_scw(scw), .o_bcr(basic_configuration_register), .o_fsr(final_station_register), .o_alarm_val(alarm_val), .o_gm_wr_ok(gm_ok), .o_mail_ok(mail_ok),
    .o_frame_tick(frame_tick), .o_cycle_tick(cycle_tick), .o_alarm(alarm), .o_stop_irq(stop_irq));
  npc_peer_model peer_m (.i_clk(i_clk), .i_peer(peer), .i_admit(admit), .o_link(link));
  always @(posedge i_clk)
  begin
    cyc++;
    if (stop_irq === 1'b1) irq_seen = 1'b1;
    if (cyc == 100000)
    begin
      bad_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task put(input bit to_bcr, input logic [15:0] d);
    @(negedge i_clk);
    if (to_bcr) bcr_wr = '{1'b1, d};
    else scw_wr = '{1'b1, d};
    @(negedge i_clk);
    bcr_wr.wr = 1'b0;
    scw_wr.wr = 1'b0;
  endtask
  task rsz(input logic [5:0] fs);
    @(negedge i_clk) resize = '{1'b1, fs};
    @(negedge i_clk) resize.valid = 1'b0;
  endtask
  task gm(input logic [8:0] a, input logic exp);
    @(negedge i_clk) gm_wr = '{1'b1, a};
    #1;
    chk("gm gate", 16'(exp), 16'(gm_ok));
    @(negedge i_clk) gm_wr = '0;
  endtask
  task wait_ph(input int b, output int t);
    int k;
    t = 0;
    for (k = 0; k < 40000 && scw[b] !== 1'b1; k++)
    begin
      @(posedge i_clk);
      #1;
      if (cycle_tick === 1'b1) t++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk("scw reset", 16'h0000, scw);
    chk("fsr reset", 16'h003F, 16'(final_station_register));
  endtask
  task t_config;
    put(1'b1, 16'h0101);
    chk("bcr locked", 16'h0000, basic_configuration_register);
    put(1'b0, 16'h8000);
    chk("monitor bit", 16'h8000, scw);
    put(1'b1, 16'h0101);
    chk("bcr taken", 16'h0101, basic_configuration_register);
    put(1'b0, 16'h0000);
    @(negedge i_clk);
    alarm_in = 7'h01;
    alarm_wr = 1'b1;
    @(negedge i_clk) alarm_wr = 1'b0;
    chk("alarm preset", 16'h0001, 16'(alarm_val));
    gm(9'h010, 1'b1);
  endtask
  task t_start;
    int k;
    put(1'b0, 16'h0100);
    chk("start bit", 16'h0100, scw & 16'hFF00);
    put(1'b0, 16'h8100);
    chk("monitor refused", 16'h0100, scw & 16'hFF00);
    gm(9'h008, 1'b1);
    gm(9'h010, 1'b0);
    rsz(6'h00);
    chk("fsr resize", 16'h0000, 16'(final_station_register));
    mail_req = 1'b1;
    wait_ph(10, n);
    chk("start ticks", 16'(n >= 2 && n <= 3), 16'h0001);
    chk("wait phase", 16'h0002, 16'(scw[11:9]));
    chk("mail in wait", 16'h0000, 16'(mail_ok));
    for (k = 0; k < 5000 && frame_tick !== 1'b1; k++) @(posedge i_clk) #1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    while (frame_tick !== 1'b1 && n < 5000);
    chk("frame clocks", 16'((int'(npc_pkg::LOF_STD) + 1) * 2 * int'(npc_pkg::BIT_CYC_0)), 16'(n));
    for (k = 0; k < 10000 && cycle_tick !== 1'b1; k++) @(posedge i_clk) #1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    while (cycle_tick !== 1'b1 && n < 20000);
    chk("cycle clocks",
      16'((int'(npc_pkg::LOF_STD) + 1) * 2 * int'(npc_pkg::BIT_CYC_0) * (int'(npc_pkg::PUBLIC_FRAME_COUNT) + 1)), 16'(n));
  endtask
  task t_run;
    int k;
    @(negedge i_clk);
    peer = 1'b1;
    admit = 1'b0;
    wait_ph(11, n);
    chk("break phase", 16'h0004, 16'(scw[11:9]));
    chk("mail in break", 16'h0000, 16'(mail_ok));
    @(negedge i_clk);
    admit = 1'b1;
    wait_ph(9, n);
    chk("run phase", 16'h0001, 16'(scw[11:9]));
    chk("mail in run", 16'h0001, 16'(mail_ok));
    for (k = 0; k < 10000 && alarm !== 1'b1; k++) @(posedge i_clk) #1;
    chk("alarm", 16'h0001, 16'(alarm));
    chk("station time", 16'h0001, 16'(scw[6:0]));
  endtask
  task t_slot;
    irq_seen = 1'b0;
    rsz(6'h00);
    repeat (3) @(negedge i_clk);
    chk("slot stop", 16'h0010, 16'(scw[13:8]));
    chk("stop irq", 16'h0001, 16'(irq_seen));
  endtask
  task t_restart;
    put(1'b0, 16'h0100);
    chk("flags cleared", 16'h0001, 16'(scw[13:8]));
    irq_seen = 1'b0;
    put(1'b0, 16'h0000);
    repeat (2) @(negedge i_clk);
    chk("host stop", 16'h0000, 16'(scw[11:8]));
    chk("host stop irq", 16'h0001, 16'(irq_seen));
  endtask

  initial
  begin
    repeat (5) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    t_reset();
    t_config();
    t_start();
    t_run();
    t_slot();
    t_restart();
    end_sim();
  end
endmodule
